// file: rtl/afsc_filter_config.sv
/*
  Eight per-setup filter configuration registers of a multiplexed
  sigma-delta converter, the decode of the active setup's fields for the
  filter datapath, the conversion restart on any filter config write, and the output
  word pacing of direct sinc3 decimation mode.
  Assumes i_clk is the modulator clock and that the serial port engine
  delivers register accesses as one-cycle strobes on i_req.
*/
// Summary of operation
// - any filter config write aborts conversion, restarts at first sequenced channel
// - each filter config register is 16 bits, resets to 0x0500
// - direct decimation bit set: bits 14:0 are sinc3 rate, other options ignored
// - direct mode single channel word rate is modulator clock over 32 times rate
// - direct decimation bit clear: bits 14:12 and 7 reserved, host writes zero, device keeps them zero
// - postfilter enable bit 11 turns postfilter on, only with filter type 00
// - postfilter select 010/011/101/110 give 27/21.25/20/16.67 SPS, reset 0x5
// - filter type 00 selects sinc5 plus sinc1, other codes select sinc3
// - five-bit output rate field selects data rate for sinc5 plus sinc1
// - seven more registers at following addresses share layout and reset value
`timescale 1ns/1ps

module afsc_filter_config (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire afsc_pkg::afsc_req_t i_req,
  input wire logic [afsc_pkg::SETUP_W-1:0] i_active_setup,
  output logic [afsc_pkg::DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic o_restart,
  output afsc_pkg::afsc_cfg_t o_cfg,
  output logic o_word_strobe
);
  import afsc_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic hits_filter_config(input logic [ADDR_W-1:0] addr);
    hits_filter_config = (addr >= FILTER_SETUP_ZERO_CONFIG_ADDR) &&
                         (addr <= FILTER_SETUP_LAST_CONFIG_ADDR);
  endfunction

  function automatic logic [SETUP_W-1:0] setup_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] diff;
    diff = addr - FILTER_SETUP_ZERO_CONFIG_ADDR;
    setup_index = diff[SETUP_W-1:0];
  endfunction

  function automatic logic [DATA_W-1:0] write_value(input logic [DATA_W-1:0] wdata);
    if (wdata[DIRECT_DECIMATION_SELECT_BIT]) begin
      write_value = wdata & DIRECT_WRITE_MASK;
    end else begin
      write_value = wdata & NORMAL_WRITE_MASK;
    end
  endfunction

  function automatic afsc_cfg_t decode_cfg(input logic [DATA_W-1:0] r);
    afsc_cfg_t c;
    logic [FILTER_TYPE_SELECT_W-1:0] ftype;
    logic [POSTFILTER_SELECT_W-1:0] psel;
    c = '0;
    ftype = r[FILTER_TYPE_SELECT_LSB +: FILTER_TYPE_SELECT_W];
    psel = r[POSTFILTER_SELECT_LSB +: POSTFILTER_SELECT_W];
    if (r[DIRECT_DECIMATION_SELECT_BIT]) begin
      // every other option is dropped in direct mode
      c.direct_mode = 1'b1;
      c.decim_rate = r[DECIM_RATE_W-1:0];
      c.sinc3_sel = 1'b1;
    end else begin
      c.sinc3_sel = (ftype != FILTER_TYPE_SINC5_SINC1);
      c.postfilter_on = r[POSTFILTER_ENABLE_BIT] && (ftype == FILTER_TYPE_SINC5_SINC1);
      c.postfilter_select = psel;
      c.postfilter_valid = (psel == POSTFILTER_27SPS) || (psel == POSTFILTER_21SPS) ||
                           (psel == POSTFILTER_20SPS) || (psel == POSTFILTER_16SPS);
      c.output_rate_select = r[OUTPUT_RATE_SELECT_LSB +: OUTPUT_RATE_SELECT_W];
    end
    decode_cfg = c;
  endfunction

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] cfg_reg [NUM_SETUPS];
  logic [DATA_W-1:0] cfg_next [NUM_SETUPS];
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic restart_reg;
  logic restart_next;
  logic cfg_write;

  always_comb begin
    cfg_write = i_req.write && hits_filter_config(i_req.addr);
    for (int i = 0; i < NUM_SETUPS; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    if (cfg_write) begin
      cfg_next[setup_index(i_req.addr)] = write_value(i_req.wdata);
    end
    restart_next = cfg_write;
    rvalid_next = i_req.read;
    rdata_next = rdata_reg;
    if (i_req.read) begin
      if (hits_filter_config(i_req.addr)) begin
        rdata_next = cfg_reg[setup_index(i_req.addr)];
      end else begin
        rdata_next = '0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < NUM_SETUPS; i++) begin
        cfg_reg[i] <= FILTER_CONFIG_RESET;
      end
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_SETUPS; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      restart_reg <= restart_next;
    end
  end

  // ----------------------------------------------------------------------
  // active setup decode
  // ----------------------------------------------------------------------
  afsc_cfg_t active_cfg_reg;
  afsc_cfg_t active_cfg_next;

  always_comb begin
    active_cfg_next = decode_cfg(cfg_reg[i_active_setup]);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      active_cfg_reg <= '0;
    end else begin
      active_cfg_reg <= active_cfg_next;
    end
  end

  // ----------------------------------------------------------------------
  // direct decimation word pacing
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    AFSC_PACE_IDLE = 2'b00,
    AFSC_PACE_RUN = 2'b01
  } afsc_pace_t;

  afsc_pace_t pace_reg;
  afsc_pace_t pace_next;
  logic [WORD_COUNT_W-1:0] count_reg;
  logic [WORD_COUNT_W-1:0] count_next;
  logic [WORD_COUNT_W-1:0] period;
  logic strobe_reg;
  logic strobe_next;

  always_comb begin
    period = {active_cfg_reg.decim_rate, {DECIM_FACTOR_SHIFT{1'b0}}};
    pace_next = pace_reg;
    count_next = count_reg;
    strobe_next = 1'b0;
    case (pace_reg)
      AFSC_PACE_IDLE: begin
        count_next = '0;
        if (active_cfg_reg.direct_mode && (period != '0) && !restart_reg) begin
          pace_next = AFSC_PACE_RUN;
        end
      end
      AFSC_PACE_RUN: begin
        if (restart_reg || !active_cfg_reg.direct_mode || (period == '0)) begin
          // a filter config write aborts the word in progress
          pace_next = AFSC_PACE_IDLE;
          count_next = '0;
        end else if (count_reg >= period - 1'b1) begin
          count_next = '0;
          strobe_next = 1'b1;
        end else begin
          count_next = count_reg + 1'b1;
        end
      end
      default: begin
        pace_next = AFSC_PACE_IDLE;
        count_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pace_reg <= AFSC_PACE_IDLE;
      count_reg <= '0;
      strobe_reg <= 1'b0;
    end else begin
      pace_reg <= pace_next;
      count_reg <= count_next;
      strobe_reg <= strobe_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_rvalid = rvalid_reg;
  assign o_restart = restart_reg;
  assign o_cfg = active_cfg_reg;
  assign o_word_strobe = strobe_reg;

endmodule

// file: rtl/afsc_pkg.sv
/*
  Shared constants and types for the per-setup filter configuration block.
  Assumes a host-side serial port engine that presents decoded register
  reads and writes as single-cycle strobes with a register address.
*/
package afsc_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int NUM_SETUPS = 8;
  localparam int SETUP_W = 3;
  localparam logic [ADDR_W-1:0] FILTER_SETUP_ZERO_CONFIG_ADDR = 6'h28;
  localparam logic [ADDR_W-1:0] FILTER_SETUP_LAST_CONFIG_ADDR = 6'h2f;
  localparam logic [DATA_W-1:0] FILTER_CONFIG_RESET = 16'h0500;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int DIRECT_DECIMATION_SELECT_BIT = 15;
  localparam int DECIM_RATE_W = 15;
  localparam int POSTFILTER_ENABLE_BIT = 11;
  localparam int POSTFILTER_SELECT_LSB = 8;
  localparam int POSTFILTER_SELECT_W = 3;
  localparam int FILTER_TYPE_SELECT_LSB = 5;
  localparam int FILTER_TYPE_SELECT_W = 2;
  localparam int OUTPUT_RATE_SELECT_LSB = 0;
  localparam int OUTPUT_RATE_SELECT_W = 5;
  // writable bits with the direct decimation select bit clear
  localparam logic [DATA_W-1:0] NORMAL_WRITE_MASK = 16'h8f7f;
  // writable bits with the direct decimation select bit set
  localparam logic [DATA_W-1:0] DIRECT_WRITE_MASK = 16'hffff;

  // ----------------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------------
  localparam logic [FILTER_TYPE_SELECT_W-1:0] FILTER_TYPE_SINC5_SINC1 = 2'h0;
  localparam logic [POSTFILTER_SELECT_W-1:0] POSTFILTER_27SPS = 3'h2;
  localparam logic [POSTFILTER_SELECT_W-1:0] POSTFILTER_21SPS = 3'h3;
  localparam logic [POSTFILTER_SELECT_W-1:0] POSTFILTER_20SPS = 3'h5;
  localparam logic [POSTFILTER_SELECT_W-1:0] POSTFILTER_16SPS = 3'h6;

  // ----------------------------------------------------------------------
  // direct decimation timing: one word per 32 x rate modulator clocks
  // ----------------------------------------------------------------------
  localparam int DECIM_FACTOR = 32;
  localparam int DECIM_FACTOR_SHIFT = 5;
  localparam int WORD_COUNT_W = DECIM_RATE_W + DECIM_FACTOR_SHIFT;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } afsc_req_t;

  typedef struct packed {
    logic direct_mode;
    logic [DECIM_RATE_W-1:0] decim_rate;
    logic sinc3_sel;
    logic postfilter_on;
    logic [POSTFILTER_SELECT_W-1:0] postfilter_select;
    logic postfilter_valid;
    logic [OUTPUT_RATE_SELECT_W-1:0] output_rate_select;
  } afsc_cfg_t;

endpackage

// file: tb/afsc_filter_config_chk.sv
/*
  Port checker for the filter configuration block.
  Assumes one clock domain and the active-low reset of the design.
*/
`timescale 1ns/1ps

module afsc_filter_config_chk
  import afsc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire afsc_req_t i_req,
  input wire logic [SETUP_W-1:0] i_active_setup,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_restart,
  input wire afsc_cfg_t o_cfg,
  input wire logic o_word_strobe
);
  logic [WORD_COUNT_W-1:0] gap_reg;
  logic armed_reg;
  wire mapped = (i_req.addr[5:3] == 3'h5);

  // cycles since last strobe; armed while pacing is undisturbed
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_reg <= '0;
      armed_reg <= 1'b0;
    end else begin
      gap_reg <= o_word_strobe ? WORD_COUNT_W'(1) : gap_reg + 1'b1;
      armed_reg <= !o_restart && !$changed(o_cfg) && (o_word_strobe || armed_reg);
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  restart_write_a: assert property (
    i_req.write && mapped |=> o_restart) else $error("no restart after write");
  restart_cause_a: assert property (
    o_restart |-> $past(i_req.write) && $past(i_req.addr[5:3]) == 3'h5) else $error("restart without write");
  read_answer_a: assert property (
    i_req.read |=> o_rvalid) else $error("read not answered");
  reserved_zero_a: assert property (
    o_rvalid && !o_rdata[15] |-> o_rdata[14:12] == 3'h0 && !o_rdata[7]) else $error("reserved bit set");
  direct_only_a: assert property (
    o_cfg.direct_mode |-> o_cfg.sinc3_sel && !o_cfg.postfilter_on && o_cfg.output_rate_select == 5'h0)
    else $error("direct mode options");
  postfilter_order_a: assert property (
    o_cfg.postfilter_on |-> !o_cfg.sinc3_sel) else $error("postfilter with sinc3");
  postfilter_code_a: assert property (
    !o_cfg.direct_mode |-> o_cfg.postfilter_valid == (o_cfg.postfilter_select inside {3'h2, 3'h3, 3'h5, 3'h6}))
    else $error("postfilter code validity");
  word_gap_a: assert property (
    o_word_strobe |=> !o_word_strobe [*8]) else $error("strobes too close");
  word_period_a: assert property (
    o_word_strobe && armed_reg |-> gap_reg == {$past(o_cfg.decim_rate), 5'h0}) else $error("strobe period wrong");

  cover property (o_restart);
  cover property (o_word_strobe && armed_reg);
  cover property (o_cfg.postfilter_on);
endmodule

bind afsc_filter_config afsc_filter_config_chk i_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req),
  .i_active_setup(i_active_setup), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_restart(o_restart),
  .o_cfg(o_cfg), .o_word_strobe(o_word_strobe));

// file: tb/afsc_host_model.sv
/*
  Host controller model: issues single register accesses on the strobe port.
  Assumes the serial engine shape of the design's request struct.
*/
`timescale 1ns/1ps

module afsc_host_model
  import afsc_pkg::*;
(
  input wire logic i_clk,
  output afsc_req_t o_req
);
  initial o_req = '0;

  // one access; returns just after the edge that took it
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic bad);
    @(posedge i_clk);
    o_req.write <= w;
    o_req.read <= !w;
    o_req.addr <= a;
    o_req.wdata <= (bad || d[15]) ? d : (d & NORMAL_WRITE_MASK);
    @(posedge i_clk);
    o_req <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
    #1;
  endtask
endmodule

// file: tb/tb_top.sv
/*
  Self-checking bench for the filter configuration block.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
  import afsc_pkg::*;
  logic clk;
  logic nrst;
  afsc_req_t req;
  logic [SETUP_W-1:0] setup;
  logic [DATA_W-1:0] rdata;
  logic rvalid, restart, strobe;
  afsc_cfg_t cfg;
  int mismatches;
  int num_checks;

  afsc_host_model i_host (.i_clk(clk), .o_req(req));
  afsc_filter_config i_dut (.i_clk(clk), .i_nrst(nrst), .i_req(req), .i_active_setup(setup), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_restart(restart), .o_cfg(cfg), .o_word_strobe(strobe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_host.xfer(1'b0, a, 16'h0, 1'b0);
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask

  task automatic test_reset;
    for (int i = 0; i < NUM_SETUPS; i++) rd_chk(FILTER_SETUP_ZERO_CONFIG_ADDR + ADDR_W'(i), 16'h0500);
    rd_chk(6'h30, 16'h0);
    `CHK({cfg.postfilter_select, cfg.postfilter_valid, cfg.postfilter_on}, 5'b10110)
    $display("test_reset done");
  endtask

  task automatic test_fields;
    @(posedge clk);
    setup <= 3'h2;
    i_host.xfer(1'b1, 6'h2a, 16'h7fff, 1'b1);
    `CHK(restart, 1'b1)
    rd_chk(6'h2a, 16'h0f7f);
    `CHK({cfg.sinc3_sel, cfg.postfilter_on, cfg.postfilter_valid}, 3'b100)
    `CHK(cfg.output_rate_select, 5'h1f)
    i_host.xfer(1'b1, 6'h30, 16'h1234, 1'b0);
    `CHK(restart, 1'b0)
    $display("test_fields done");
  endtask

  task automatic test_post;
    logic [2:0] codes[4] = '{3'h2, 3'h3, 3'h5, 3'h6};
    @(posedge clk);
    setup <= 3'h3;
    for (int i = 0; i < 4; i++) begin
      i_host.xfer(1'b1, 6'h2b, {4'h0, 1'b1, codes[i], 8'h05}, 1'b0);
      `CHK(restart, 1'b1)
      @(posedge clk);
      #1;
      `CHK({cfg.postfilter_on, cfg.postfilter_select}, {1'b1, codes[i]})
      `CHK({cfg.postfilter_valid, cfg.output_rate_select}, 6'h25)
    end
    @(posedge clk);
    setup <= 3'h0;
    repeat (2) @(posedge clk);
    #1;
    `CHK({cfg.postfilter_on, cfg.postfilter_select}, 4'h5)
    $display("test_post done");
  endtask

  task automatic test_direct;
    int n;
    i_host.xfer(1'b1, 6'h28, 16'h8002, 1'b0);
    @(posedge clk);
    #1;
    `CHK({cfg.direct_mode, cfg.decim_rate, cfg.sinc3_sel, cfg.postfilter_valid}, {1'b1, 15'h2, 2'b10})
    n = 0;
    while (!strobe && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!strobe && n < 200);
    `CHK(n, DECIM_FACTOR * 2)
    // rewrite just after a strobe: the word in progress must be dropped and counted afresh
    i_host.xfer(1'b1, 6'h28, 16'h8002, 1'b0);
    `CHK(restart, 1'b1)
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!strobe && n < 200);
    // one cycle of restart pulse and one to re-enter the run state precede the full period
    `CHK(n, DECIM_FACTOR * 2 + 2)
    i_host.xfer(1'b1, 6'h28, 16'hf081, 1'b0);
    `CHK(restart, 1'b1)
    rd_chk(6'h28, 16'hf081);
    $display("test_direct done");
  endtask

  initial begin
    mismatches = 0;
    num_checks = 0;
    nrst = 1'b0;
    setup = 3'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    test_reset();
    test_fields();
    test_post();
    test_direct();
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
